// ==== src/sdt_pkg.sv ====
// Purpose: Shared constants for the synchronous DRAM command and data timing core.
// Assumes: CAS latency 3 operating point, burst length as a module parameter.
// Notes: Cycle counts derive from printed figures where a time is given.
package sdt_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CAS_LATENCY = 3;
  localparam int STOP_TO_HIGHZ = 3;
  localparam int CLOSE_TO_HIGHZ = 3;
  localparam int LAST_OUTPUT_TO_AUTOCLOSE = -2;
  localparam int MASK_TO_OUTPUT_LATENCY = 2;
  localparam int MASK_TO_INPUT_LATENCY = 0;
  localparam int COLUMN_COMMAND_GAP = 1;
  localparam int DEF_BURST_LEN = 4;
  localparam int NUM_BANKS = 4;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h6;
  localparam logic [3:0] CMD_CLOSE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE = 4'h0;
  typedef enum logic [1:0] {
    SDT_IDLE = 2'b00,
    SDT_READ = 2'b01,
    SDT_WRITE = 2'b10
  } sdt_burst_t;
endpackage : sdt_pkg

// ==== src/sdt_mem.sv ====
// Purpose: Byte-masked word store for the DRAM core with registered read data.
// Assumes: One write and one read port on the link clock.
// Notes: A set mask bit blocks the matching byte lane.
`timescale 1ns/1ps
module sdt_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk, // Link clock.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] waddr, // Write address.
  input wire logic [DW-1:0] wdata, // Write data.
  input wire logic [DW/8-1:0] wmask, // Byte lanes blocked when high.
  input wire logic [AW-1:0] raddr, // Read address.
  output logic [DW-1:0] rdata // Registered read data.
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DW/8; i++)
    begin
      if (we && !wmask[i])
        mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
    end
    rdata <= mem[raddr];
  end
endmodule : sdt_mem

// ==== src/sdt_core.sv ====
// Purpose: Burst data path of a four-bank synchronous DRAM on its own link clock.
// Assumes: Controller keeps all command spacing; CAS latency 3 only.
// Notes: Bank open flags cross to clk as levels; rst release is synchronized to link_clk only, the clk flops take rst directly.
`timescale 1ns/1ps
module sdt_core
  import sdt_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 6,
  parameter int BURST_LEN = DEF_BURST_LEN
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic link_clk, // DRAM link clock from the controller.
  input wire logic [3:0] cmd, // Command code: chip select, row, column, write strobes.
  input wire logic [1:0] bank, // Bank address.
  input wire logic [AW-1:0] col, // Column address.
  input wire logic auto_close, // Column command closes its row at burst end.
  input wire logic [DW/8-1:0] byte_mask, // Byte mask, high blocks a write lane; dq_oe drops for a read beat only when all bits are high.
  input wire logic [DW-1:0] dq_i, // Data pins, input side.
  output logic [DW-1:0] dq_o, // Data pins, output side.
  output logic dq_oe, // High while the device drives the data pins.
  output logic [NUM_BANKS-1:0] bank_open // Open-row flags seen on clk.
);
  localparam int CW = $clog2(BURST_LEN + 1);
  localparam int PIPE = CAS_LATENCY - 1;
  logic lrst_m_q, lrst_q;
  sdt_burst_t burst_q, burst_d;
  logic [CW-1:0] left_q, left_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [1:0] bank_q, bank_d;
  logic close_q, close_d;
  logic [NUM_BANKS-1:0] open_q, open_d;
  logic [PIPE-1:0] rd_pipe_q;
  logic [PIPE-1:0] cut_pipe_q;
  logic [DW/8-1:0] mask_p1_q, mask_p2_q;
  logic [DW-1:0] rdata;
  logic [DW-1:0] rd_hold_q;
  logic [DW/8-1:0] dq_oe_lane;
  logic oe_q;
  logic [NUM_BANKS-1:0] s1_q, s2_q, s3_q, open_sync_q;

  wire is_act = (cmd == CMD_ACTIVATE);
  wire is_read = (cmd == CMD_READ);
  wire is_write = (cmd == CMD_WRITE);
  wire is_stop = (cmd == CMD_STOP);
  wire is_close = (cmd == CMD_CLOSE);
  wire close_hit = is_close && (burst_q != SDT_IDLE) && (bank == bank_q);
  wire cut = is_stop || close_hit;
  wire col_cmd = is_read || is_write;
  wire wr_beat = (burst_q == SDT_WRITE) && !cut && !col_cmd;
  wire wr_now = is_write || wr_beat;
  wire [AW-1:0] wr_addr = is_write ? col : addr_q;
  wire rd_beat = (burst_q == SDT_READ) && !cut;
  wire rd_issue = is_read || (rd_beat && !col_cmd);
  wire [AW-1:0] rd_addr = is_read ? col : addr_q;
  wire last_beat = (left_q == CW'(1));
  wire early_close = (burst_q == SDT_READ) && close_q && !col_cmd && !cut
    && (left_q == CW'(1 - LAST_OUTPUT_TO_AUTOCLOSE - PIPE));
  wire wr_done = (burst_q == SDT_WRITE) && close_q && last_beat && wr_beat;

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      lrst_m_q <= 1'b1;
      lrst_q <= 1'b1;
    end
    else
    begin
      lrst_m_q <= 1'b0;
      lrst_q <= lrst_m_q;
    end
  end

  // Column commands restart the burst on any cycle, so back-to-back issue works.
  always_comb
  begin
    burst_d = burst_q;
    left_d = left_q;
    addr_d = addr_q;
    bank_d = bank_q;
    close_d = close_q;
    open_d = open_q;
    if (is_act)
      open_d[bank] = 1'b1;
    if (is_close)
      open_d[bank] = 1'b0;
    if (early_close || wr_done)
      open_d[bank_q] = 1'b0;
    if (col_cmd)
    begin
      burst_d = is_read ? SDT_READ : SDT_WRITE;
      left_d = CW'(BURST_LEN - 1);
      addr_d = col + AW'(1);
      bank_d = bank;
      close_d = auto_close;
      if (BURST_LEN == 1)
        burst_d = SDT_IDLE;
      if (BURST_LEN == 1 && auto_close)
        open_d[bank] = 1'b0;
    end
    else if (cut)
      burst_d = SDT_IDLE;
    else if (burst_q != SDT_IDLE)
    begin
      left_d = left_q - CW'(1);
      addr_d = addr_q + AW'(1);
      if (last_beat)
        burst_d = SDT_IDLE;
    end
  end

  always_ff @(posedge link_clk or posedge lrst_q)
  begin
    if (lrst_q)
    begin
      burst_q <= SDT_IDLE;
      left_q <= '0;
      addr_q <= '0;
      bank_q <= '0;
      close_q <= 1'b0;
      open_q <= '0;
    end
    else
    begin
      burst_q <= burst_d;
      left_q <= left_d;
      addr_q <= addr_d;
      bank_q <= bank_d;
      close_q <= close_d;
      open_q <= open_d;
    end
  end

  // Read data leaves CAS_LATENCY cycles after its column beat; the store adds one.
  always_ff @(posedge link_clk or posedge lrst_q)
  begin
    if (lrst_q)
    begin
      rd_pipe_q <= '0;
      cut_pipe_q <= '0;
      mask_p1_q <= '0;
      mask_p2_q <= '0;
      oe_q <= 1'b0;
    end
    else
    begin
      rd_pipe_q <= {rd_pipe_q[PIPE-2:0], rd_issue};
      cut_pipe_q <= {cut_pipe_q[PIPE-2:0], cut && !is_read};
      mask_p1_q <= byte_mask;
      mask_p2_q <= mask_p1_q;
      oe_q <= rd_pipe_q[PIPE-1] && !cut_pipe_q[PIPE-1];
    end
  end

  sdt_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk(link_clk),
    .we(wr_now),
    .waddr(wr_addr),
    .wdata(dq_i),
    .wmask(byte_mask),
    .raddr(rd_addr),
    .rdata(rdata)
  );

  // Two stages after the store keep each word in step with its drive enable.
  always_ff @(posedge link_clk or posedge lrst_q)
  begin
    if (lrst_q)
    begin
      rd_hold_q <= '0;
      dq_o <= '0;
    end
    else
    begin
      rd_hold_q <= rdata;
      dq_o <= rd_hold_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DW/8; g++)
    begin : g_lane
      assign dq_oe_lane[g] = oe_q && !mask_p2_q[g];
    end
  endgenerate
  assign dq_oe = |dq_oe_lane;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      open_sync_q <= '0;
    end
    else
    begin
      s1_q <= open_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        if (s2_q[i] == s3_q[i])
          open_sync_q[i] <= s3_q[i];
      end
    end
  end
  assign bank_open = open_sync_q;
endmodule : sdt_core

// ==== sim/sdt_ctl.sv ====
// Purpose: Controller model that drives the core command pins.
// Assumes: The bench makes the link clock.
// Notes: Pins move on the falling edge only.
`timescale 1ns/1ps
module sdt_ctl
  import sdt_pkg::*;
(
  input wire logic link_clk, // Link clock.
  output logic [3:0] cmd = CMD_NOP, // Command.
  output logic [1:0] bank = 2'h0, // Bank.
  output logic [5:0] col = 6'h00, // Column.
  output logic auto_close = 1'b0, // Close at end.
  output logic [1:0] byte_mask = 2'h0, // Lane blocks.
  output logic [15:0] dq_i = 16'h0000 // Write data.
);
  task cyc(logic [3:0] c, logic [2:0] b, logic [5:0] a, logic [15:0] d, logic [1:0] m);
    @(negedge link_clk);
    {cmd, auto_close, bank, col, dq_i, byte_mask} <= {c, b, a, d, m};
  endtask : cyc
endmodule : sdt_ctl

// ==== sim/sdt_core_asserts.sv ====
// Purpose: Data pin drive timing checks on the core for reads, writes and reset.
// Assumes: Commands are sampled on the link clock rise.
// Notes: The bind follows the module.
`timescale 1ns/1ps
module sdt_core_asserts
  import sdt_pkg::*;
#(parameter int DW = 16) (
  input wire logic rst, // Reset.
  input wire logic link_clk, // Link clock.
  input wire logic [3:0] cmd, // Command.
  input wire logic [DW/8-1:0] byte_mask, // Lane blocks.
  input wire logic dq_oe // Pin drive.
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst);
  wire qt = cmd == CMD_NOP && byte_mask == '0;
  sequence s_rd;
    cmd == CMD_READ && byte_mask == '0;
  endsequence
  sequence s_cut(k);
    s_rd ##1 cmd == k && byte_mask == '0 ##1 qt;
  endsequence
  a_read_late: assert property (s_rd ##1 qt [*2] |=> dq_oe) else $error("no read data");
  a_burst_len: assert property (s_rd ##1 qt [*6] |=> !dq_oe) else $error("long burst");
  a_col_again: assert property (s_rd ##1 s_rd ##1 qt [*5] |=> dq_oe ##1 !dq_oe) else $error("no restart");
  a_stop_cut: assert property (s_cut(CMD_STOP) |=> dq_oe ##1 !dq_oe) else $error("stop cutoff");
  a_close_cut: assert property (s_cut(CMD_CLOSE) |=> dq_oe ##1 !dq_oe) else $error("close cutoff");
  a_mask_late: assert property (s_rd ##1 cmd == CMD_NOP && byte_mask == '1 ##1 qt |-> ##1 !dq_oe ##1 dq_oe)
    else $error("mask delay");
  a_write_off: assert property (cmd == CMD_WRITE ##1 qt [*7] |=> !dq_oe) else $error("write drove pins");
  a_reset_off: assert property ($fell(rst) |-> !dq_oe) else $error("drive after reset");
endmodule : sdt_core_asserts
bind sdt_core sdt_core_asserts #(.DW(DW)) sdt_core_asserts_i (.rst, .link_clk, .cmd, .byte_mask, .dq_oe);

// ==== sim/sdt_core_test.sv ====
// Purpose: Directed checks of the core burst path.
// Assumes: The controller model issues every command.
// Notes: Entry j of so holds outputs after cycle j-1.
`timescale 1ns/1ps
module sdt_core_test;
  import sdt_pkg::*;
  logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, auto_close, dq_oe;
  logic [3:0] cmd, bank_open;
  logic [1:0] bank, byte_mask;
  logic [5:0] col;
  logic [15:0] dq_i, dq_o, so [10];
  logic soe [10];
  int mismatches = 0, tests_run = 0;
  initial forever #5 clk = ~clk;
  initial #3 forever #6 link_clk = ~link_clk;
  sdt_ctl sdt_ctl_i (.*);
  sdt_core sdt_core_i (.*);
  task chk(string n, logic [15:0] s, e);
    tests_run++;
    mismatches += int'(s !== e);
    if (s !== e) $display("FAIL %s exp %h seen %h", n, e, s);
  endtask : chk
  task run(logic [3:0] c, logic [5:0] a, logic [15:0] d, logic [3:0] kc = CMD_NOP, int ks = 1,
    logic [1:0] m1 = 2'h0, logic [2:0] b = 3'h0);
    for (int j = 0; j < 10; j++)
    begin
      sdt_ctl_i.cyc(j == 0 ? c : j == ks ? kc : CMD_NOP, b, a, d + 16'(j), j == 1 ? m1 : 2'h0);
      so[j] = dq_o;
      soe[j] = dq_oe;
    end
  endtask : run
  task s_bank;
    sdt_ctl_i.cyc(CMD_ACTIVATE, 3'h1, 6'h00, 16'h0000, 2'h0);
    repeat (6) sdt_ctl_i.cyc(CMD_NOP, 3'h1, 6'h00, 16'hFFFF, 2'h0);
    chk("open", bank_open, 16'h0002);
    run(CMD_READ, 6'h00, 16'h0000, CMD_NOP, 1, 2'h0, 3'h5);
    chk("shut", bank_open, 16'h0000);
  endtask : s_bank
  task s_wmask;
    run(CMD_WRITE, 6'h00, 16'h1100);
    run(CMD_WRITE, 6'h00, 16'h22F0, CMD_NOP, 1, 2'h2);
    run(CMD_READ, 6'h00, 16'h0000);
    chk("w0", so[3], 16'h22F0);
    chk("w1", so[4], 16'h11F1);
  endtask : s_wmask
  task s_cut;
    for (int i = 0; i < 2; i++)
    begin
      run(CMD_WRITE, 6'h10, 16'h4400);
      run(CMD_WRITE, 6'h10, 16'h3300, i ? CMD_CLOSE : CMD_STOP, 2);
      run(CMD_READ, 6'h10, 16'h0000);
      chk("w1", so[4], 16'h3301);
      chk("w2", so[5], 16'h4402);
      run(CMD_READ, 6'h10, 16'h0000, i ? CMD_CLOSE : CMD_STOP);
      chk("on", soe[3], 16'h0001);
      chk("off", soe[4], 16'h0000);
    end
  endtask : s_cut
  task s_rmask;
    run(CMD_READ, 6'h00, 16'h0000, CMD_NOP, 1, 2'h3);
    chk("oe3", soe[3], 16'h0000);
  endtask : s_rmask
  task s_again;
    run(CMD_READ, 6'h00, 16'h0000, CMD_READ);
    chk("d4", so[4], 16'h22F0);
    chk("oe7", soe[7], 16'h0001);
  endtask : s_again
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge link_clk);
    s_bank;
    s_wmask;
    s_cut;
    s_rmask;
    s_again;
    conclude;
  end
  initial
  begin
    #50000;
    mismatches++;
    conclude;
  end
endmodule : sdt_core_test
